// ---- bench/imc_master_properties.sv ----
// Purpose: timing checks on the bus side of the cycle sequencer
// Assumes: strobes active high, one clock domain
// Notes: counters hold distances in double-rate clock periods
`timescale 1ns/1ns
module imc_master_properties (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // request side
  input wire logic reqValid,
  input wire imc_pkg::imc_req_t req,
  input wire logic reqReady,
  input wire logic rdValid,
  input wire logic [imc_pkg::IMC_DATA_W-1:0] rdData,
  // bus side
  input wire imc_pkg::imc_strobe_t strobe,
  input wire logic [imc_pkg::IMC_LA_HI:imc_pkg::IMC_LA_LO] latchAddr,
  input wire logic [imc_pkg::IMC_SA_HI:0] sysAddr,
  input wire logic byteHigh,
  input wire logic ioChanReady,
  input wire logic [imc_pkg::IMC_DATA_W-1:0] busData
);
  import imc_pkg::*;
  logic cmd;
  logic ioCmd;
  logic [4:0] cmdLen;
  logic [4:0] minLen;
  logic [4:0] sinceCmd;
  logic [4:0] ioAge;
  assign ioCmd = strobe.ioRd | strobe.ioWr;
  assign cmd = ioCmd | strobe.memRd | strobe.memWr | strobe.lowMemRd | strobe.lowMemWr;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmdLen <= 5'h00;
      minLen <= 5'h09;
      sinceCmd <= 5'h1f;
      ioAge <= 5'h00;
    end else begin
      cmdLen <= cmd ? ((cmdLen == 5'h1f) ? cmdLen : cmdLen + 5'h01) : 5'h00;
      sinceCmd <= (cmd && cmdLen == 5'h00) ? 5'h01 : sinceCmd + 5'(sinceCmd != 5'h1f);
      ioAge <= $rose(ioCmd) ? 5'h01 : ioAge + 5'(ioAge != 5'h00 && ioAge != 5'h1f);
      if (reqValid && reqReady) begin
        minLen <= (!req.kind[1] && req.wide) ? ((req.len == IMC_LEN_2BCLK) ? 5'h04 :
          (req.len == IMC_LEN_4BCLK) ? 5'h08 : 5'h06) : 5'h09;
      end
    end
  end
  property p_ale_width;
    $rose(strobe.ale) |=> !strobe.ale;
  endproperty
  a_ale_width: assert property (p_ale_width) else $error("address strobe width");
  property p_ale_to_cmd;
    $rose(strobe.ale) |-> !cmd ##1 !cmd ##1 $rose(cmd);
  endproperty
  a_ale_to_cmd: assert property (p_ale_to_cmd) else $error("strobe to command");
  property p_la_setup;
    $fell(strobe.ale) |-> latchAddr == $past(latchAddr, 5) && sysAddr == $past(sysAddr);
  endproperty
  a_la_setup: assert property (p_la_setup) else $error("address before strobe");
  property p_addr_setup;
    $rose(cmd) |-> sysAddr == $past(sysAddr, 2) && byteHigh == $past(byteHigh, 2);
  endproperty
  a_addr_setup: assert property (p_addr_setup) else $error("address setup");
  property p_cmd_width;
    $fell(cmd) |-> cmdLen >= minLen;
  endproperty
  a_cmd_width: assert property (p_cmd_width) else $error("command too short");
  property p_cmd_to_ale;
    $rose(strobe.ale) |-> sinceCmd >= 5'd10;
  endproperty
  a_cmd_to_ale: assert property (p_cmd_to_ale) else $error("command to strobe");
  property p_cmd_spacing;
    $rose(cmd) |-> sinceCmd >= 5'd12;
  endproperty
  a_cmd_spacing: assert property (p_cmd_spacing) else $error("command spacing");
  property p_recover;
    $fell(cmd) |-> !strobe.ale && !cmd ##1 !cmd ##1 !cmd;
  endproperty
  a_recover: assert property (p_recover) else $error("command recovery");
  property p_io_hold;
    ioAge != 5'h00 && ioAge < 5'd19 |-> $stable(sysAddr);
  endproperty
  a_io_hold: assert property (p_io_hold) else $error("io address hold");
  property p_wait_hold;
    cmd && !ioChanReady |=> cmd && $stable(sysAddr);
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("wait not honoured");
  property p_rdy_return;
    $rose(ioChanReady) && cmd |=> cmd && !strobe.ale && $stable(sysAddr) ##1
      !strobe.ale && $stable(sysAddr);
  endproperty
  a_rdy_return: assert property (p_rdy_return) else $error("ready return");
endmodule : imc_master_properties

// ---- bench/imc_slave_model.sv ----
// Purpose: behavioural bus slave answering the cycle sequencer
// Assumes: waitLen zero means a zero-wait slave
// Notes: data that is not valid toggles every cycle
`timescale 1ns/1ns
module imc_slave_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // bus side
  input wire imc_pkg::imc_strobe_t strobe,
  input wire logic [imc_pkg::IMC_SA_HI:0] sysAddr,
  output logic ioChanReady,
  output logic [imc_pkg::IMC_DATA_W-1:0] busData,
  // behaviour control
  input wire logic wide,
  input wire logic [4:0] waitLen
);
  import imc_pkg::*;
  logic [5:0] age;
  logic [5:0] lim;
  logic [15:0] junk;
  logic rd;
  assign rd = strobe.memRd | strobe.lowMemRd | strobe.ioRd;
  assign lim = wide ? 6'h02 : 6'h05;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      age <= 6'h00;
      junk <= 16'h0f0f;
    end else begin
      age <= (|strobe[5:0]) ? age + 6'h01 : 6'h00;
      junk <= ~junk;
    end
  end
  // wait requested no earlier than the limit after command start
  assign ioChanReady = !(waitLen != 5'h00 && age >= lim && age < lim + 6'(waitLen));
  // data valid from the limit after command start while ready, released at command negate
  assign busData = (rd && age >= lim && ioChanReady) ? 16'(sysAddr) ^ 16'h5a5a : junk;
endmodule : imc_slave_model

// ---- bench/tb_top.sv ----
// Purpose: self-checking bench for the cycle sequencer
// Assumes: slave model data pattern is address xor 5a5a
// Notes: outputs sampled on falling edges
`timescale 1ns/1ns
module tb_top;
  import imc_pkg::*;
  logic sys_clk, rst, reqValid, reqReady, rdValid, byteHigh, ioChanReady;
  imc_req_t req;
  imc_strobe_t strobe;
  logic [15:0] rdData, busData;
  logic [23:17] latchAddr;
  logic [19:0] sysAddr;
  logic [4:0] waitLen;
  int nMismatch = 0;
  int nCompared = 0;
  imc_master dut (.sys_clk(sys_clk), .rst(rst), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .rdValid(rdValid), .rdData(rdData), .strobe(strobe),
    .latchAddr(latchAddr), .sysAddr(sysAddr), .byteHigh(byteHigh),
    .ioChanReady(ioChanReady), .busData(busData));
  imc_slave_model partner (.sys_clk(sys_clk), .rst(rst), .strobe(strobe), .sysAddr(sysAddr),
    .ioChanReady(ioChanReady), .busData(busData), .wide(req.wide), .waitLen(waitLen));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      nMismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic conclude;
    $display("compared %0d mismatched %0d", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic run_cycle(input imc_kind_t k, input logic w, input imc_len_t l,
                           input logic [4:0] wt, input logic [23:0] a, input int expW);
    imc_strobe_t exp, seen;
    int t, aleT, cmdT, cmdW;
    logic [16:0] rd;
    logic lm;
    exp = '0;
    seen = '0;
    // memory addresses below one megabyte also raise the low-memory strobe
    lm = (a[23:IMC_LOWMEM_TOP] == 4'h0);
    case (k)
      IMC_MEM_RD: begin
        exp.memRd = 1'b1;
        exp.lowMemRd = lm;
      end
      IMC_MEM_WR: begin
        exp.memWr = 1'b1;
        exp.lowMemWr = lm;
      end
      IMC_IO_RD: exp.ioRd = 1'b1;
      default: exp.ioWr = 1'b1;
    endcase
    t = 0; aleT = 0; cmdT = 0; cmdW = 0; rd = '0;
    @(posedge sys_clk);
    waitLen <= wt;
    reqValid <= 1'b1;
    req <= '{kind: k, wide: w, lowMem: lm, len: l, addr: a, byteHigh: ~a[0]};
    do begin @(negedge sys_clk); t++; end while (reqReady !== 1'b1 && t < 100);
    if (reqReady !== 1'b1) begin
      nMismatch++;
      $display("mismatch request ready expected 1 seen %b", reqReady);
      conclude();
    end
    @(posedge sys_clk);
    reqValid <= 1'b0;
    t = 0;
    while (t < 120 && !(cmdT != 0 && strobe[5:0] === 6'h00)) begin
      @(negedge sys_clk);
      t++;
      if (strobe.ale === 1'b1) aleT = t;
      if (rdValid === 1'b1) rd = {1'b1, rdData};
      if (|strobe[5:0] === 1'b1) begin
        if (cmdT == 0) begin
          cmdT = t;
          seen = strobe;
          check("upper address", 32'(a[23:17]), 32'(latchAddr));
          check("system address", {a[19:0], ~a[0]}, {sysAddr, byteHigh});
        end
        cmdW++;
      end
    end
    repeat (2) begin @(negedge sys_clk); if (rdValid === 1'b1) rd = {1'b1, rdData}; end
    if (t >= 120) begin nMismatch++; $display("mismatch cycle end expected done seen hang"); conclude(); end
    check("strobe to command", 2, cmdT - aleT);
    check("command kind", 32'(exp), 32'(seen));
    if (wt == 5'h00) check("command width", expW, cmdW);
    else check("extended command", 1, cmdW > expW);
    if (!k[0]) check("read data", {1'b1, a[15:0] ^ 16'h5a5a}, rd);
  endtask : run_cycle
  task automatic t_kinds;
    for (int w = 0; w < 2; w++)
      for (int i = 0; i < 4; i++)
        run_cycle(imc_kind_t'(i), w[0], IMC_LEN_STD, 5'h00, 24'h9e31c4 ^ 24'(i * 3),
                  (w == 1 && i < 2) ? 6 : 9);
  endtask : t_kinds
  task automatic t_lens;
    run_cycle(IMC_MEM_RD, 1'b1, IMC_LEN_2BCLK, 5'h00, 24'h00fffe, 4);
    run_cycle(IMC_MEM_WR, 1'b1, IMC_LEN_4BCLK, 5'h00, 24'hfe0001, 8);
  endtask : t_lens
  task automatic t_waits;
    run_cycle(IMC_IO_RD, 1'b1, IMC_LEN_STD, 5'h0c, 24'h0003f8, 9);
    run_cycle(IMC_MEM_RD, 1'b0, IMC_LEN_STD, 5'h06, 24'h5c0a31, 9);
    run_cycle(IMC_MEM_WR, 1'b1, IMC_LEN_2BCLK, 5'h03, 24'h7ffff0, 4);
  endtask : t_waits
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    rst = 1'b1;
    reqValid = 1'b0;
    req = '0;
    waitLen = 5'h00;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_kinds();
    t_lens();
    t_waits();
    conclude();
  end
endmodule : tb_top
bind imc_master imc_master_properties u_props (.sys_clk(sys_clk), .rst(rst),
  .reqValid(reqValid), .req(req), .reqReady(reqReady), .rdValid(rdValid), .rdData(rdData),
  .strobe(strobe), .latchAddr(latchAddr), .sysAddr(sysAddr), .byteHigh(byteHigh),
  .ioChanReady(ioChanReady), .busData(busData));

// ---- core/imc_master.sv ----
// Purpose: expansion bus master cycle sequencer (address strobe, commands, ready wait)
// Assumes: sys_clk is the double-rate bus clock; slave inputs synchronous to it
// Notes: strobes are active high here; pad logic inverts them for the bus
`timescale 1ns/1ns

// Function
// RULE_01: intervals counted in double-rate clock periods
// RULE_02: upper address valid five clocks before strobe negates
// RULE_03: system address valid one clock before strobe negates
// RULE_04: memory address valid two clocks before command
// RULE_05: I/O address valid two clocks before command
// RULE_06: address strobe held at least one clock
// RULE_07: address strobe two clocks before any command
// RULE_08: standard command held nine clocks minimum
// RULE_09: ten clocks from command to next strobe
// RULE_10: twelve clocks between same-type command assertions
// RULE_11: three clocks from command negate to next
// RULE_12: command negated one clock before next strobe
// RULE_13: I/O address held nineteen clocks after command
// RULE_14: slave negates ready only after 2T/5T
// RULE_15: ready low extends command and holds address
// RULE_16: command stays one clock after ready returns
// RULE_17: two clocks from ready return to strobe
// RULE_18: address held two clocks after ready returns
// RULE_19: slave read data by 2T/5T after command
// RULE_20: read data valid one clock after ready
// RULE_21: read data may vanish at command negate
// RULE_22: 16-bit memory commands of 2, 3, 4 bus clocks
module imc_master (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // request side
  input wire logic reqValid,
  input wire imc_pkg::imc_req_t req,
  output logic reqReady,
  output logic rdValid,
  output logic [imc_pkg::IMC_DATA_W-1:0] rdData,
  // bus side
  output imc_pkg::imc_strobe_t strobe,
  output logic [imc_pkg::IMC_LA_HI:imc_pkg::IMC_LA_LO] latchAddr,
  output logic [imc_pkg::IMC_SA_HI:0] sysAddr,
  output logic byteHigh,
  input wire logic ioChanReady,
  input wire logic [imc_pkg::IMC_DATA_W-1:0] busData
);
  import imc_pkg::*;

  imc_state_t state;
  imc_req_t cur;
  logic [IMC_CNT_W-1:0] phaseCnt;
  logic [IMC_CNT_W-1:0] cmdLen;
  logic [IMC_CNT_W-1:0] sinceCmd;
  logic [IMC_CNT_W-1:0] sinceNeg;
  logic [IMC_CNT_W-1:0] sinceRdy;
  logic cmdSeen;
  logic negSeen;
  logic isRead;
  logic isIo;
  logic [IMC_CNT_W-1:0] holdMin;
  logic next_cmd;

  // command length in double-rate periods for this request
  function automatic logic [IMC_CNT_W-1:0] cmd_periods(input imc_req_t r);
    logic [IMC_CNT_W-1:0] res;
    res = IMC_T_CMD_STD;
    if (r.kind inside {IMC_MEM_RD, IMC_MEM_WR} && r.wide) begin
      case (r.len)
        IMC_LEN_2BCLK: res = 5'(IMC_BCLK_2 * IMC_T_BCLK); // [RULE_22]
        IMC_LEN_4BCLK: res = 5'(IMC_BCLK_4 * IMC_T_BCLK); // [RULE_22]
        default: res = 5'(IMC_BCLK_3 * IMC_T_BCLK); // [RULE_22]
      endcase
    end
    return res;
  endfunction : cmd_periods

  // strobe set for a kind, honouring the low-memory path
  function automatic imc_strobe_t cmd_decode(input imc_req_t r);
    imc_strobe_t s;
    s = '0;
    case (r.kind)
      IMC_MEM_RD: begin
        s.memRd = 1'b1;
        s.lowMemRd = r.lowMem;
      end
      IMC_MEM_WR: begin
        s.memWr = 1'b1;
        s.lowMemWr = r.lowMem;
      end
      IMC_IO_RD: s.ioRd = 1'b1;
      IMC_IO_WR: s.ioWr = 1'b1;
      default: s = '0;
    endcase
    return s;
  endfunction : cmd_decode

  assign isRead = (cur.kind == IMC_MEM_RD) || (cur.kind == IMC_IO_RD);
  assign isIo = (cur.kind == IMC_IO_RD) || (cur.kind == IMC_IO_WR);
  // I/O standard cycles keep address nineteen periods after command
  assign holdMin = isIo ? IMC_T_IO_ADDR_HOLD : IMC_CNT_ZERO; // [RULE_13]

  // all edges launched on the double-rate clock [RULE_01]
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= IMC_IDLE;
      phaseCnt <= '0;
      cmdLen <= '0;
      sinceRdy <= '0;
      cur <= '0;
    end else begin
      case (state)
        IMC_IDLE: begin
          phaseCnt <= '0;
          if (reqValid && reqReady) begin
            cur <= req;
            cmdLen <= cmd_periods(req);
            state <= IMC_SETUP;
          end
        end
        IMC_SETUP: begin
          // upper address settles before the strobe window [RULE_02]
          phaseCnt <= phaseCnt + IMC_CNT_ONE;
          if (phaseCnt + IMC_CNT_ONE >= IMC_T_LA_SETUP - IMC_T_ALE_WIDTH) begin
            phaseCnt <= '0;
            state <= IMC_ALE;
          end
        end
        IMC_ALE: begin
          // strobe high one period, address already valid [RULE_03] [RULE_06]
          phaseCnt <= phaseCnt + IMC_CNT_ONE;
          if (phaseCnt + IMC_CNT_ONE >= IMC_T_ALE_WIDTH) begin
            phaseCnt <= IMC_T_ALE_WIDTH;
            state <= IMC_RECOV;
          end
        end
        IMC_RECOV: begin
          // strobe-to-command, address setup and command recovery gaps
          phaseCnt <= phaseCnt + IMC_CNT_ONE;
          if (phaseCnt + IMC_CNT_ONE >= IMC_T_ALE_TO_CMD // [RULE_07] [RULE_04] [RULE_05]
              && (!negSeen || sinceNeg + IMC_CNT_ONE >= IMC_T_CMD_RECOV) // [RULE_11]
              && (!cmdSeen || sinceCmd + IMC_CNT_ONE >= IMC_T_CMD_TO_CMD)) begin // [RULE_10]
            phaseCnt <= '0;
            state <= IMC_CMD;
          end
        end
        IMC_CMD: begin
          phaseCnt <= phaseCnt + IMC_CNT_ONE;
          if (!ioChanReady) begin
            state <= IMC_WAIT; // [RULE_15]
          end else if (phaseCnt + IMC_CNT_ONE + IMC_CNT_ONE >= cmdLen) begin // [RULE_08]
            // leave one period early: the tail period is the last one with the command high
            state <= IMC_TAIL;
            sinceRdy <= IMC_T_RDY_TO_NEG;
          end
        end
        IMC_WAIT: begin
          // command and address frozen until ready returns [RULE_15]
          phaseCnt <= phaseCnt + IMC_CNT_ONE;
          if (ioChanReady) begin
            sinceRdy <= '0;
            state <= IMC_TAIL;
          end
        end
        IMC_TAIL: begin
          // command held one more period after ready [RULE_16]
          sinceRdy <= sinceRdy + IMC_CNT_ONE;
          phaseCnt <= phaseCnt + IMC_CNT_ONE;
          if (sinceRdy + IMC_CNT_ONE >= IMC_T_RDY_TO_NEG
              && phaseCnt + IMC_CNT_ONE >= cmdLen) begin
            state <= IMC_IDLE;
          end
        end
        default: state <= IMC_IDLE;
      endcase
    end
  end

  // history since last command assertion and negation
  assign next_cmd = (state == IMC_RECOV) && (phaseCnt + IMC_CNT_ONE >= IMC_T_ALE_TO_CMD)
    && (!negSeen || sinceNeg + IMC_CNT_ONE >= IMC_T_CMD_RECOV)
    && (!cmdSeen || sinceCmd + IMC_CNT_ONE >= IMC_T_CMD_TO_CMD);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sinceCmd <= '0;
      cmdSeen <= 1'b0;
    end else if (next_cmd) begin
      sinceCmd <= '0;
      cmdSeen <= 1'b1;
    end else if (sinceCmd != '1) begin
      sinceCmd <= sinceCmd + IMC_CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sinceNeg <= '0;
      negSeen <= 1'b0;
    end else if (state == IMC_TAIL && phaseCnt + IMC_CNT_ONE >= cmdLen
                 && sinceRdy + IMC_CNT_ONE >= IMC_T_RDY_TO_NEG) begin
      sinceNeg <= '0;
      negSeen <= 1'b1;
    end else if (sinceNeg != '1) begin
      sinceNeg <= sinceNeg + IMC_CNT_ONE;
    end
  end

  // accept a new cycle only once strobe and address-hold spacing from the previous one is met; command spacing waits in recovery
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reqReady <= 1'b0;
    end else begin
      reqReady <= (state == IMC_IDLE) && !(reqValid && reqReady)
        && (!cmdSeen || sinceCmd + IMC_CNT_ONE >= IMC_T_CMD_TO_ALE - IMC_T_LA_SETUP) // [RULE_09]
        && (!negSeen || sinceNeg >= IMC_T_RDY_TO_ALE - IMC_T_ALE_WIDTH) // [RULE_12] [RULE_17]
        && (!cmdSeen || sinceCmd + IMC_CNT_ONE >= holdMin); // [RULE_13] [RULE_18]
    end
  end

  // strobe outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strobe <= '0;
    end else begin
      strobe <= '0;
      if (state == IMC_SETUP && phaseCnt + IMC_CNT_ONE >= IMC_T_LA_SETUP - IMC_T_ALE_WIDTH) begin
        strobe.ale <= 1'b1; // [RULE_06]
      end
      if (next_cmd || state == IMC_WAIT
          || (state == IMC_CMD && (!ioChanReady || phaseCnt + IMC_CNT_ONE < cmdLen))
          || (state == IMC_CMD && phaseCnt + IMC_CNT_ONE >= cmdLen)
          || (state == IMC_TAIL && !(sinceRdy + IMC_CNT_ONE >= IMC_T_RDY_TO_NEG
                                      && phaseCnt + IMC_CNT_ONE >= cmdLen))) begin
        strobe <= cmd_decode(cur); // [RULE_08] [RULE_16]
      end
    end
  end

  // address held from setup until the next request is accepted
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      latchAddr <= '0;
      sysAddr <= '0;
      byteHigh <= 1'b0;
    end else if (reqValid && reqReady) begin
      latchAddr <= req.addr[IMC_LA_HI:IMC_LA_LO]; // [RULE_02]
      sysAddr <= req.addr[IMC_SA_HI:0]; // [RULE_03] [RULE_18]
      byteHigh <= req.byteHigh;
    end
  end

  // read data captured at the last command period, while still driven
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdValid <= 1'b0;
      rdData <= '0;
    end else begin
      rdValid <= 1'b0;
      if (state == IMC_TAIL && isRead && sinceRdy + IMC_CNT_ONE >= IMC_T_RDY_DATA_R
          && phaseCnt + IMC_CNT_ONE >= cmdLen) begin
        rdValid <= 1'b1; // [RULE_20] [RULE_21]
        rdData <= busData; // [RULE_19]
      end
    end
  end

endmodule : imc_master

// ---- include/imc_pkg.sv ----
// Purpose: shared constants and types for the expansion bus master cycle sequencer
// Assumes: every interval is counted in periods of the double-rate bus clock, except IMC_BCLK_2, IMC_BCLK_3 and IMC_BCLK_4, which are in bus clocks
// Notes: counts are the least legal figures except IMC_T_RD_LATE_W and IMC_T_RD_LATE_N, which are latest; the sequencer never goes below them
package imc_pkg;

  // cycle kinds
  typedef enum logic [1:0] {
    IMC_MEM_RD = 2'b00,
    IMC_MEM_WR = 2'b01,
    IMC_IO_RD = 2'b10,
    IMC_IO_WR = 2'b11
  } imc_kind_t;

  // command length for 16-bit memory accesses, in bus clocks
  typedef enum logic [1:0] {
    IMC_LEN_STD = 2'b00,
    IMC_LEN_2BCLK = 2'b01,
    IMC_LEN_4BCLK = 2'b10
  } imc_len_t;

  typedef enum logic [2:0] {
    IMC_IDLE = 3'b000,
    IMC_ALE = 3'b001,
    IMC_SETUP = 3'b010,
    IMC_CMD = 3'b011,
    IMC_WAIT = 3'b100,
    IMC_TAIL = 3'b101,
    IMC_RECOV = 3'b110
  } imc_state_t;

  typedef struct packed {
    imc_kind_t kind;
    logic wide;
    logic lowMem;
    imc_len_t len;
    logic [23:0] addr;
    logic byteHigh;
  } imc_req_t;

  typedef struct packed {
    logic ale;
    logic memRd;
    logic memWr;
    logic lowMemRd;
    logic lowMemWr;
    logic ioRd;
    logic ioWr;
  } imc_strobe_t;

  localparam int unsigned IMC_CNT_W = 5;
  localparam int unsigned IMC_ADDR_W = 24;
  localparam int unsigned IMC_LA_HI = 23;
  localparam int unsigned IMC_LA_LO = 17;
  localparam int unsigned IMC_SA_HI = 19;
  localparam int unsigned IMC_DATA_W = 16;
  localparam int unsigned IMC_LOWMEM_TOP = 20;

  // counts in double-rate clock periods
  localparam logic [IMC_CNT_W-1:0] IMC_T_LA_SETUP = 5'h05;
  localparam logic [IMC_CNT_W-1:0] IMC_T_ALE_WIDTH = 5'h01;
  localparam logic [IMC_CNT_W-1:0] IMC_T_ALE_TO_CMD = 5'h02;
  localparam logic [IMC_CNT_W-1:0] IMC_T_SA_TO_CMD = 5'h02;
  localparam logic [IMC_CNT_W-1:0] IMC_T_CMD_STD = 5'h09;
  localparam logic [IMC_CNT_W-1:0] IMC_T_CMD_TO_ALE = 5'h0a;
  localparam logic [IMC_CNT_W-1:0] IMC_T_CMD_TO_CMD = 5'h0c;
  localparam logic [IMC_CNT_W-1:0] IMC_T_CMD_RECOV = 5'h03;
  localparam logic [IMC_CNT_W-1:0] IMC_T_IO_ADDR_HOLD = 5'h13;
  localparam logic [IMC_CNT_W-1:0] IMC_T_RDY_TO_NEG = 5'h01;
  localparam logic [IMC_CNT_W-1:0] IMC_T_RDY_TO_ALE = 5'h02;
  localparam logic [IMC_CNT_W-1:0] IMC_T_RDY_ADDR_HOLD = 5'h02;
  localparam logic [IMC_CNT_W-1:0] IMC_T_RDY_EARLY_W = 5'h02;
  localparam logic [IMC_CNT_W-1:0] IMC_T_RDY_EARLY_N = 5'h05;
  localparam logic [IMC_CNT_W-1:0] IMC_T_RD_LATE_W = 5'h02;
  localparam logic [IMC_CNT_W-1:0] IMC_T_RD_LATE_N = 5'h05;
  localparam logic [IMC_CNT_W-1:0] IMC_T_RDY_DATA_R = 5'h01;
  // one bus clock is two double-rate periods
  localparam logic [IMC_CNT_W-1:0] IMC_T_BCLK = 5'h02;
  localparam logic [IMC_CNT_W-1:0] IMC_BCLK_2 = 5'h02;
  localparam logic [IMC_CNT_W-1:0] IMC_BCLK_3 = 5'h03;
  localparam logic [IMC_CNT_W-1:0] IMC_BCLK_4 = 5'h04;
  localparam logic [IMC_CNT_W-1:0] IMC_CNT_ONE = 5'h01;
  localparam logic [IMC_CNT_W-1:0] IMC_CNT_ZERO = 5'h00;

endpackage : imc_pkg
